// *** rtl/fpk_pkg.sv ***
package fpk_pkg;

	// Fuse map inside the nonvolatile store.
	localparam int FUSE_W       = 17;
	localparam int OP_LSB       = 0;
	localparam int OP_W         = 6;
	localparam int HYS_LSB      = 6;
	localparam int HYS_W        = 2;
	localparam int PAR_BIT      = 8;
	localparam int LOCKREG_LSB  = 9;
	localparam int LOCKREG_W    = 8;
	localparam int LOCK_BIT_POS = 4;
	localparam int LOCK_BIT     = LOCKREG_LSB + LOCK_BIT_POS;

	// Key figures, counted in mid-level pulses.
	localparam logic [3:0] KEY_PAR_MIDS   = 4'h1;
	localparam logic [3:0] KEY_HYS_MIDS   = 4'h3;
	localparam logic [3:0] KEY_DOWN_MIDS  = 4'h4;
	localparam logic [3:0] KEY_LOCK_MIDS  = 4'h5;
	localparam logic [3:0] KEY_CHKLO_MIDS = 4'h7;
	localparam logic [3:0] KEY_CHKHI_MIDS = 4'h8;
	localparam logic [3:0] KEY_BIT_MIDS   = 4'h9;
	localparam logic [3:0] KEY_BLOW_MIDS  = 4'hB;

	// Try-mode entry codes and limits.
	localparam logic [5:0] OP_UP_INIT   = 6'h01;
	localparam logic [5:0] OP_DOWN_INIT = 6'h3F;
	localparam logic [5:0] OP_BIT_INIT  = 6'h01;
	localparam logic [5:0] OP_BIT_LAST  = 6'h20;
	localparam logic [5:0] OP_MAX       = 6'h3F;
	localparam logic [1:0] HYS_INIT     = 2'h1;
	localparam logic [1:0] HYS_MAX      = 2'h3;
	localparam logic       PAR_INIT     = 1'b1;
	localparam logic [7:0] ADDR_INIT    = 8'h01;

	// Timing.
	localparam int CLK_FREQ_MHZ       = 200;
	localparam int BLOW_TIME_US       = 100;
	localparam int BLOW_CYCLES_DEFAULT = BLOW_TIME_US * CLK_FREQ_MHZ;

	// Register bus map, byte addresses.
	localparam logic [3:0] ADR_STATUS = 4'h0;
	localparam logic [3:0] ADR_FUSES  = 4'h4;
	localparam logic [3:0] ADR_CODE   = 4'h8;
	localparam logic [3:0] ADR_CTRL   = 4'hC;
	localparam logic [1:0] CTRL_RESET = 2'h1;

	typedef enum logic [3:0] {
		REG_OPUP, REG_OPDN, REG_OPBIT, REG_HYS, REG_PAR, REG_LOCK
	} fpk_reg_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_H1, ST_TRY, ST_BLOW_ADDR, ST_BLOW_HOLD, ST_DONE
	} fpk_state_t;

endpackage

// *** rtl/fpk_fuse_store.sv ***
`timescale 1ns/1ps
// Nonvolatile fuse array. Only a fresh die clears it; a supply cycle does not.
module fpk_fuse_store
	import fpk_pkg::*;
#(
	parameter int WIDTH = FUSE_W
)
(
	input  wire logic             mclk,       // System clock.
	input  wire logic             fuseInit,   // Virgin-die clear, async.
	input  wire logic             blowStb,    // Blow one fuse this cycle.
	input  wire logic [4:0]       blowIdx,    // Index of the fuse to blow.
	output logic      [WIDTH-1:0] fuses       // Registered fuse states.
);

	logic [WIDTH-1:0] fuse_q;
	logic [WIDTH-1:0] fuse_d;

	always_comb
	begin
		fuse_d = fuse_q;
		if (blowStb && (32'(blowIdx) < WIDTH))
		begin
			fuse_d[blowIdx] = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge fuseInit)
	begin
		if (fuseInit)
		begin
			fuse_q <= '0;
		end
		else
		begin
			fuse_q <= fuse_d;
		end
	end

	assign fuses = fuse_q;

endmodule // fpk_fuse_store

// *** rtl/fpk_key_decoder.sv ***
`timescale 1ns/1ps
module fpk_key_decoder
	import fpk_pkg::*;
#(
	parameter int BLOW_CYCLES = BLOW_CYCLES_DEFAULT
)
(
	input  wire logic                 mclk,               // System clock, 200 MHz.
	input  wire logic                 sys_rst,            // Supply cycle, async, high.
	input  wire logic                 fuseInit,           // Virgin-die fuse clear, async.
	input  wire logic                 midLevelIn,         // Supply above mid threshold.
	input  wire logic                 highLevelIn,        // Supply above high threshold.
	input  wire logic [FUSE_W-1:0]    fuseWeakIn,         // Per-fuse marginal sense.
	input  wire logic [3:0]           avs_address,        // Avalon byte address.
	input  wire logic                 avs_read,           // Avalon read.
	input  wire logic                 avs_write,          // Avalon write.
	input  wire logic [31:0]          avs_writedata,      // Avalon write data.
	input  wire logic [3:0]           avs_byteenable,     // Avalon byte enables.
	output logic      [31:0]          avs_readdata,       // Avalon read data.
	output logic                      avs_waitrequest,    // Avalon wait.
	output logic      [OP_W-1:0]      operatePoint,       // Active operate point code.
	output logic      [HYS_W-1:0]     switchHysteresis,   // Active hysteresis code.
	output logic                      marginalFuse,       // Marginal fuse found.
	output logic                      blowDrive,          // Blow current enabled.
	output logic                      locked              // Lock fuse blown.
);

	// Input synchronisers: three stages, a change counts when stages two and three agree.
	logic [FUSE_W+1:0] sync1_q, sync2_q, sync3_q, filt_q, filt_d;
	logic [FUSE_W+1:0] rawIn;
	logic              midLvl, highLvl, midPrev_q, highPrev_q, sawHigh_q, sawHigh_d;
	logic [FUSE_W-1:0] fuseWeak;

	assign rawIn = {fuseWeakIn, highLevelIn, midLevelIn};

	always_comb
	begin
		filt_d = (sync3_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));
		sawHigh_d = sawHigh_q;
		if (highLvl)
		begin
			sawHigh_d = 1'b1;
		end
		else if (!midLvl)
		begin
			sawHigh_d = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync1_q    <= '0;
			sync2_q    <= '0;
			sync3_q    <= '0;
			filt_q     <= '0;
			midPrev_q  <= 1'b0;
			highPrev_q <= 1'b0;
			sawHigh_q  <= 1'b0;
		end
		else
		begin
			sync1_q    <= rawIn;
			sync2_q    <= sync1_q;
			sync3_q    <= sync2_q;
			filt_q     <= filt_d;
			midPrev_q  <= midLvl;
			highPrev_q <= highLvl;
			sawHigh_q  <= sawHigh_d;
		end
	end

	assign midLvl   = filt_q[0];
	assign highLvl  = filt_q[1];
	assign fuseWeak = filt_q[FUSE_W+1:2];

	// Mid and high pulse events act on falling edges, highRise on the rising high edge; a high pulse also passes the mid level.
	logic pulseEn, midPulse, highPulse, highRise;
	assign midPulse  = pulseEn && midPrev_q && !midLvl && !sawHigh_q;
	assign highPulse = pulseEn && highPrev_q && !highLvl;
	assign highRise  = pulseEn && !highPrev_q && highLvl;

	// Key decoder and code counters.
	fpk_state_t        state_q, state_d;
	fpk_reg_t          reg_q, reg_d;
	logic [3:0]        midCnt_q, midCnt_d;
	logic [OP_W-1:0]   tryOp_q, tryOp_d;
	logic [HYS_W-1:0]  tryHys_q, tryHys_d;
	logic              tryPar_q, tryPar_d;
	logic [7:0]        addr_q, addr_d;
	logic [31:0]       holdCnt_q, holdCnt_d;
	logic              blowDone_q, blowDone_d;
	logic              blowStb;
	logic [4:0]        blowIdx;
	logic [FUSE_W-1:0] fuses;
	logic              blowAllowed, parityNeed;
	logic [2:0]        addrBit;

	assign locked     = fuses[LOCK_BIT];
	assign parityNeed = ^fuses[PAR_BIT-1:0];

	always_comb
	begin
		addrBit = 3'h0;
		for (int i = 0; i < 8; i++)
		begin
			if (addr_q[i])
			begin
				addrBit = 3'(i);
			end
		end
		blowIdx = 5'h1F;
		case (reg_q)
			REG_OPUP: blowIdx = 5'(OP_LSB) + {2'h0, addrBit};
			REG_HYS:  blowIdx = 5'(HYS_LSB) + {2'h0, addrBit};
			REG_PAR:  blowIdx = 5'(PAR_BIT);
			REG_LOCK: blowIdx = 5'(LOCKREG_LSB) + {2'h0, addrBit};
			default:  blowIdx = 5'h1F;
		endcase
		// Addresses past the field width select no fuse until addr_q shifts out to zero, which selects bit 0.
		blowAllowed = !locked;
		if ((reg_q == REG_OPUP) && (addrBit >= 3'(OP_W)))
		begin
			blowAllowed = 1'b0;
		end
		if ((reg_q == REG_HYS) && (addrBit >= 3'(HYS_W)))
		begin
			blowAllowed = 1'b0;
		end
		if ((reg_q == REG_PAR) && !parityNeed)
		begin
			blowAllowed = 1'b0;
		end
	end

	always_comb
	begin
		state_d    = state_q;
		reg_d      = reg_q;
		midCnt_d   = midCnt_q;
		tryOp_d    = tryOp_q;
		tryHys_d   = tryHys_q;
		tryPar_d   = tryPar_q;
		addr_d     = addr_q;
		holdCnt_d  = holdCnt_q;
		blowDone_d = blowDone_q;
		blowStb    = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				if (highPulse)
				begin
					state_d  = ST_H1;
					midCnt_d = 4'h0;
				end
				else if (midPulse)
				begin
					state_d = ST_DONE;
				end
			end
			ST_H1:
			begin
				if (midPulse && (midCnt_q != 4'hF))
				begin
					midCnt_d = midCnt_q + 4'h1;
				end
				if (highPulse)
				begin
					state_d  = ST_TRY;
					midCnt_d = 4'h0;
					case (midCnt_q)
						4'h0:
						begin
							reg_d   = REG_OPUP;
							tryOp_d = OP_UP_INIT;
						end
						KEY_PAR_MIDS:
						begin
							reg_d    = REG_PAR;
							tryPar_d = PAR_INIT;
						end
						KEY_HYS_MIDS:
						begin
							reg_d    = REG_HYS;
							tryHys_d = HYS_INIT;
						end
						KEY_LOCK_MIDS: reg_d = REG_LOCK;
						default:       state_d = ST_DONE;
					endcase
				end
			end
			ST_TRY:
			begin
				if (midPulse)
				begin
					if (midCnt_q != 4'hF)
					begin
						midCnt_d = midCnt_q + 4'h1;
					end
					case (reg_q)
						REG_OPUP: tryOp_d = tryOp_q + 6'h01;
						REG_OPDN: tryOp_d = tryOp_q - 6'h01;
						REG_OPBIT:
						begin
							if (tryOp_q == OP_BIT_LAST)
							begin
								tryOp_d = 6'h00;
							end
							else if (tryOp_q == 6'h00)
							begin
								tryOp_d = OP_BIT_INIT;
							end
							else
							begin
								tryOp_d = tryOp_q << 1;
							end
						end
						REG_HYS:
						begin
							if (tryHys_q != HYS_MAX)
							begin
								tryHys_d = tryHys_q + 2'h1;
							end
						end
						default: tryPar_d = tryPar_q;
					endcase
				end
				if (highPulse)
				begin
					midCnt_d = 4'h0;
					addr_d   = ADDR_INIT;
					if (midCnt_q == KEY_BLOW_MIDS)
					begin
						state_d = ST_BLOW_ADDR;
					end
					else if ((reg_q == REG_OPUP) && (midCnt_q == KEY_DOWN_MIDS))
					begin
						reg_d   = REG_OPDN;
						tryOp_d = OP_DOWN_INIT;
					end
					else if ((reg_q == REG_OPUP) && (midCnt_q == KEY_BIT_MIDS))
					begin
						reg_d   = REG_OPBIT;
						tryOp_d = OP_BIT_INIT;
					end
					else
					begin
						state_d = ST_DONE;
					end
				end
			end
			ST_BLOW_ADDR:
			begin
				if (midPulse && (reg_q != REG_PAR))
				begin
					addr_d = addr_q << 1;
				end
				if (highRise)
				begin
					state_d   = ST_BLOW_HOLD;
					holdCnt_d = '0;
				end
			end
			ST_BLOW_HOLD:
			begin
				if (!highLvl)
				begin
					state_d = ST_DONE;
				end
				else if (holdCnt_q == 32'(BLOW_CYCLES - 1))
				begin
					blowStb    = blowAllowed;
					blowDone_d = blowAllowed;
					state_d    = ST_DONE;
				end
				else
				begin
					holdCnt_d = holdCnt_q + 32'h1;
				end
			end
			ST_DONE:    state_d = ST_DONE;
			default:    state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q    <= ST_IDLE;
			reg_q      <= REG_OPUP;
			midCnt_q   <= 4'h0;
			tryOp_q    <= 6'h00;
			tryHys_q   <= 2'h0;
			tryPar_q   <= 1'b0;
			addr_q     <= ADDR_INIT;
			holdCnt_q  <= '0;
			blowDone_q <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			reg_q      <= reg_d;
			midCnt_q   <= midCnt_d;
			tryOp_q    <= tryOp_d;
			tryHys_q   <= tryHys_d;
			tryPar_q   <= tryPar_d;
			addr_q     <= addr_d;
			holdCnt_q  <= holdCnt_d;
			blowDone_q <= blowDone_d;
		end
	end

	fpk_fuse_store #(
		.WIDTH (FUSE_W)
	) u_store (
		.mclk     (mclk),
		.fuseInit (fuseInit),
		.blowStb  (blowStb),
		.blowIdx  (blowIdx),
		.fuses    (fuses)
	);

	// Fuse checks and the parameters the sensor uses.
	logic tryAct, opTry, chkLo, chkHi;
	logic [OP_W-1:0] opPt_q, opPt_d;
	logic [HYS_W-1:0] hys_q, hys_d;
	logic marg_q, marg_d;

	assign tryAct = (state_q == ST_TRY);
	assign opTry  = tryAct && (reg_q inside {REG_OPUP, REG_OPDN, REG_OPBIT});
	assign chkLo  = tryAct && (reg_q == REG_HYS) && (midCnt_q == KEY_CHKLO_MIDS);
	assign chkHi  = tryAct && (reg_q == REG_HYS) && (midCnt_q == KEY_CHKHI_MIDS);

	always_comb
	begin
		opPt_d = fuses[OP_LSB +: OP_W];
		hys_d  = fuses[HYS_LSB +: HYS_W];
		if (opTry)
		begin
			opPt_d = fuses[OP_LSB +: OP_W] | tryOp_q;
		end
		if (tryAct && (reg_q == REG_HYS) && !chkLo && !chkHi)
		begin
			hys_d = fuses[HYS_LSB +: HYS_W] | tryHys_q;
		end
		marg_d = (chkHi && |(fuses & fuseWeak)) ||
			(chkLo && |(~fuses & fuseWeak));
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			opPt_q <= 6'h00;
			hys_q  <= 2'h0;
			marg_q <= 1'b0;
		end
		else
		begin
			opPt_q <= opPt_d;
			hys_q  <= hys_d;
			marg_q <= marg_d;
		end
	end

	assign operatePoint     = opPt_q;
	assign switchHysteresis = hys_q;
	assign marginalFuse     = marg_q;
	assign blowDrive        = (state_q == ST_BLOW_HOLD) && blowAllowed;

	// Avalon-MM slave: one wait cycle, then the answer.
	logic        ack_q, ack_d;
	logic [1:0]  ctrl_q, ctrl_d;
	logic [31:0] rdata_q, rdata_d;

	assign pulseEn = ctrl_q[0];

	always_comb
	begin
		ack_d   = (avs_read || avs_write) && !ack_q;
		ctrl_d  = ctrl_q;
		rdata_d = rdata_q;
		if (ack_d && avs_read)
		begin
			case (avs_address)
				ADR_STATUS: rdata_d = {16'h0, midCnt_q, reg_q, 1'b0, state_q,
					tryPar_q, marg_q, blowDone_q, locked};
				ADR_FUSES:  rdata_d = {15'h0, fuses};
				ADR_CODE:   rdata_d = {14'h0, tryHys_q, addr_q, 2'h0, tryOp_q};
				ADR_CTRL:   rdata_d = {30'h0, ctrl_q};
				default:    rdata_d = 32'h0;
			endcase
		end
		// The write lands at the edge where the master sees waitrequest low.
		if (ack_q && avs_write && (avs_address == ADR_CTRL) && avs_byteenable[0])
		begin
			ctrl_d = avs_writedata[1:0];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ack_q   <= 1'b0;
			ctrl_q  <= CTRL_RESET;
			rdata_q <= 32'h0;
		end
		else
		begin
			ack_q   <= ack_d;
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign avs_readdata    = rdata_q;

endmodule // fpk_key_decoder

// *** dv/fpk_pulse_prog.sv ***
`timescale 1ns/1ps
module fpk_pulse_prog
#(
	parameter int HOLD = 40
)
(
	input  wire logic mclk,      // System clock.
	output logic      midLevel,  // Supply above mid level.
	output logic      highLevel  // Supply above high level.
);
	initial
	begin
		midLevel = 1'b0;
		highLevel = 1'b0;
	end
	task automatic lvl(input logic m, input logic h, input int n);
		@(posedge mclk);
		midLevel <= m;
		highLevel <= h;
		repeat (n) @(posedge mclk);
	endtask
	task automatic mid(input int n);
		repeat (n)
		begin
			lvl(1'b1, 1'b0, 7);
			lvl(1'b0, 1'b0, 7);
		end
	endtask
	// A high pulse raises and drops the mid level in the same cycle as the high level.
	task automatic high(input int n);
		repeat (n)
		begin
			lvl(1'b1, 1'b1, 7);
			lvl(1'b0, 1'b0, 7);
		end
	endtask
	// A key is five alternating groups of high and mid pulses; zero skips a group.
	task automatic key(input int h1, m1, h2, m2, h3);
		high(h1);
		mid(m1);
		high(h2);
		mid(m2);
		high(h3);
	endtask
	// The blow pulse is held, then the supply rests before power-down.
	task automatic blow();
		lvl(1'b1, 1'b1, HOLD);
		lvl(1'b0, 1'b0, 20);
	endtask
endmodule // fpk_pulse_prog

// *** dv/fpk_key_decoder_sva.sv ***
`timescale 1ns/1ps
module fpk_key_decoder_sva
	import fpk_pkg::*;
#(
	parameter int BLOW_CYCLES = BLOW_CYCLES_DEFAULT
)
(
	input wire logic              mclk,             // Clock.
	input wire logic              sys_rst,          // Supply cycle.
	input wire logic              midLevelIn,       // Mid level.
	input wire logic              highLevelIn,      // High level.
	input wire logic [FUSE_W-1:0] fuseWeakIn,       // Weak sense.
	input wire logic [3:0]        avs_address,      // Bus address.
	input wire logic              avs_read,         // Bus read.
	input wire logic              avs_write,        // Bus write.
	input wire logic [31:0]       avs_readdata,     // Bus read data.
	input wire logic              avs_waitrequest,  // Bus wait.
	input wire logic [OP_W-1:0]   operatePoint,     // Operate point.
	input wire logic [HYS_W-1:0]  switchHysteresis, // Hysteresis.
	input wire logic              marginalFuse,     // Marginal flag.
	input wire logic              blowDrive,        // Blow current.
	input wire logic              locked            // Lock fuse.
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic [15:0] blowRun_q;
	logic [15:0] blowRun_d;
	always_comb
	begin
		blowRun_d = blowDrive ? blowRun_q + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			blowRun_q <= 16'h0000;
		else
			blowRun_q <= blowRun_d;
	end
	sequence quietMid;
		!midLevelIn [*8];
	endsequence
	sequence quietHigh;
		!highLevelIn [*6];
	endsequence
	sequence noWeak;
		(fuseWeakIn == '0) [*6];
	endsequence
	sequence busDone;
		avs_read && !avs_waitrequest;
	endsequence
	lock_blocks_blow_a: assert property (locked |-> !blowDrive)
		else $error("Blow current while locked.");
	blow_needs_high_a: assert property (quietHigh |-> !blowDrive)
		else $error("Blow current without a held high level.");
	blow_single_a: assert property (blowRun_q <= 16'(BLOW_CYCLES + 2))
		else $error("Blow current held too long.");
	wait_once_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("Bus answer not one cycle after request.");
	unmapped_zero_a: assert property (busDone ##0 (avs_address[1:0] != 2'h0) |-> avs_readdata == 32'h0)
		else $error("Unmapped read not zero.");
	lock_status_a: assert property (busDone ##0 (avs_address == ADR_STATUS) |-> avs_readdata[0] == locked)
		else $error("Status lock bit differs from lock output.");
	lock_kept_a: assert property (locked |=> locked)
		else $error("Lock fuse lost.");
	quiet_code_a: assert property (quietMid |-> $stable(operatePoint) && $stable(switchHysteresis))
		else $error("Code changed without a mid pulse.");
	weak_none_a: assert property (noWeak |-> !marginalFuse)
		else $error("Marginal flag with no weak fuse.");
endmodule // fpk_key_decoder_sva

bind fpk_key_decoder fpk_key_decoder_sva #(.BLOW_CYCLES(BLOW_CYCLES)) fpk_key_decoder_sva_inst
(
	.mclk(mclk), .sys_rst(sys_rst), .midLevelIn(midLevelIn), .highLevelIn(highLevelIn),
	.fuseWeakIn(fuseWeakIn), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.operatePoint(operatePoint), .switchHysteresis(switchHysteresis),
	.marginalFuse(marginalFuse), .blowDrive(blowDrive), .locked(locked)
);

// *** dv/fpk_key_decoder_test.sv ***
`timescale 1ns/1ps
module fpk_key_decoder_test
	import fpk_pkg::*;
;
	localparam int BC = 20;
	logic              mclk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              fuseInit = 1'b1;
	logic [FUSE_W-1:0] fuseWeakIn = '0;
	logic [3:0]        avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_writedata;
	logic [3:0]        avs_byteenable;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic [OP_W-1:0]   operatePoint;
	logic [HYS_W-1:0]  switchHysteresis;
	logic              marginalFuse;
	logic              blowDrive;
	logic              locked;
	logic              midLevel;
	logic              highLevel;
	logic              snap = 1'b0;
	logic [31:0]       noteQ[$];
	logic [31:0]       maskQ[$];
	int                err_count = 0;
	int                checks_done = 0;
	integer            seed = 6;
	always #2.5 mclk = ~mclk;
	fpk_pulse_prog #(.HOLD(2 * BC)) fpk_pulse_prog_inst
	(
		.mclk(mclk), .midLevel(midLevel), .highLevel(highLevel)
	);
	fpk_key_decoder #(.BLOW_CYCLES(BC)) fpk_key_decoder_inst
	(
		.mclk(mclk), .sys_rst(sys_rst), .fuseInit(fuseInit), .midLevelIn(midLevel),
		.highLevelIn(highLevel), .fuseWeakIn(fuseWeakIn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .operatePoint(operatePoint),
		.switchHysteresis(switchHysteresis), .marginalFuse(marginalFuse),
		.blowDrive(blowDrive), .locked(locked)
	);
	task automatic complete_run();
		$display("checks_done=%0d err_count=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic compare(input logic [31:0] got, input string what);
		logic [31:0] e;
		logic [31:0] m;
		checks_done++;
		e = noteQ.size() ? noteQ.pop_front() : 32'hXXXX_XXXX;
		m = maskQ.size() ? maskQ.pop_front() : 32'hFFFF_FFFF;
		if ((got & m) !== (e & m))
		begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got & m, e & m);
		end
	endtask
	// Results appear at a finished bus read or at a requested output snapshot.
	always @(posedge mclk)
	begin
		if (avs_read && avs_waitrequest === 1'b0)
			compare(avs_readdata, "readback");
		if (snap)
			compare({22'h0, marginalFuse, locked, switchHysteresis, operatePoint}, "outputs");
	end
	task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= d;
		for (n = 0; n < 20; n++)
		begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n == 20)
		begin
			err_count++;
			$display("Error at %0t: bus answer missing", $time);
			complete_run();
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		noteQ.push_back(e);
		maskQ.push_back(m);
		bus(1'b1, a, 32'h0);
	endtask
	// Output snapshot packed as marginal, locked, hysteresis, operate point.
	task automatic chk(input logic [9:0] e);
		noteQ.push_back({22'h0, e});
		maskQ.push_back(32'h0000_03FF);
		repeat (10) @(posedge mclk);
		snap <= 1'b1;
		@(posedge mclk);
		snap <= 1'b0;
	endtask
	task automatic pcycle();
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	initial
	begin
		repeat (60000) @(posedge mclk);
		err_count++;
		$display("Error at %0t: run too long", $time);
		complete_run();
	end
	initial
	begin
		avs_address <= 4'h0;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= 32'h0;
		avs_byteenable <= 4'hF;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		fuseInit <= 1'b0;
		rd(ADR_STATUS, 32'h0, 32'h0000_0001);
		rd(ADR_FUSES, 32'h0, 32'hFFFF_FFFF);
		rd(ADR_CTRL, 32'h1, 32'h0000_0001);
		rd(4'h2, 32'h0, 32'hFFFF_FFFF);
		bus(1'b0, 4'h6, 32'h0);
		// A control write without its low byte enable must leave the control bits alone.
		avs_byteenable <= 4'hE;
		bus(1'b0, ADR_CTRL, 32'h0);
		avs_byteenable <= 4'hF;
		rd(ADR_CTRL, 32'h1, 32'h0000_0001);
		bus(1'b0, ADR_CTRL, 32'h0);
		fpk_pulse_prog_inst.key(2, 0, 0, 0, 0);
		chk(10'h000);
		bus(1'b0, ADR_CTRL, 32'h1);
		fpk_pulse_prog_inst.key(2, 0, 0, 0, 0);
		chk(10'h001);
		fpk_pulse_prog_inst.mid(62);
		chk(10'h03F);
		fpk_pulse_prog_inst.mid(6);
		chk(10'h005);
		pcycle();
		chk(10'h000);
		fpk_pulse_prog_inst.key(2, 4, 1, 0, 0);
		chk(10'h03F);
		fpk_pulse_prog_inst.mid(1);
		chk(10'h03E);
		pcycle();
		fpk_pulse_prog_inst.key(2, 9, 1, 0, 0);
		chk(10'h001);
		for (int i = 1; i < 6; i++)
		begin
			fpk_pulse_prog_inst.mid(1);
			chk(10'(1 << i));
		end
		pcycle();
		fpk_pulse_prog_inst.key(1, 3, 1, 0, 0);
		chk(10'h040);
		fpk_pulse_prog_inst.mid(2);
		chk(10'h0C0);
		pcycle();
		fuseWeakIn <= 17'($random(seed)) | 17'h00001;
		fpk_pulse_prog_inst.key(1, 3, 1, 7, 0);
		chk(10'h200);
		pcycle();
		fuseWeakIn <= '0;
		fpk_pulse_prog_inst.key(1, 3, 1, 7, 0);
		chk(10'h000);
		pcycle();
		fpk_pulse_prog_inst.key(2, 11, 1, 0, 0);
		fpk_pulse_prog_inst.mid(2);
		fpk_pulse_prog_inst.blow();
		pcycle();
		rd(ADR_FUSES, 32'h4, 32'hFFFF_FFFF);
		chk(10'h004);
		fpk_pulse_prog_inst.key(1, 1, 1, 11, 1);
		fpk_pulse_prog_inst.blow();
		pcycle();
		rd(ADR_FUSES, 32'h104, 32'hFFFF_FFFF);
		fpk_pulse_prog_inst.key(1, 5, 1, 11, 1);
		fpk_pulse_prog_inst.mid(4);
		fpk_pulse_prog_inst.blow();
		pcycle();
		rd(ADR_FUSES, 32'h2104, 32'hFFFF_FFFF);
		chk(10'h104);
		fpk_pulse_prog_inst.key(2, 11, 1, 0, 0);
		fpk_pulse_prog_inst.blow();
		pcycle();
		rd(ADR_FUSES, 32'h2104, 32'hFFFF_FFFF);
		fuseWeakIn <= 17'h02000;
		fpk_pulse_prog_inst.key(1, 3, 1, 8, 0);
		chk(10'h304);
		pcycle();
		fuseWeakIn <= 17'($random(seed)) & ~17'h02104;
		fpk_pulse_prog_inst.key(1, 3, 1, 8, 0);
		chk(10'h104);
		complete_run();
	end
endmodule // fpk_key_decoder_test
